// ==== logic/enc_8b10b.sv ====
// 8b/10b encoder for data octets and K28.y control characters
`default_nettype none
module enc_8b10b (
   input wire logic [7:0] octet,
   input wire logic is_k,
   input wire logic rd_in,
   output logic [9:0] symbol,
   output logic rd_out
);
   // 5b/6b codes for negative disparity, bit a first
   localparam logic [0:31][5:0] T6 = '{
      6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
      6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   // 3b/4b codes for negative disparity
   localparam logic [0:7][3:0] T4 = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   // K28.y tails following 001111
   localparam logic [0:7][3:0] K4 = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h8};
   localparam logic [5:0] K28_6B = 6'h0f;
   localparam logic [3:0] ALT7 = 4'h7;

   logic [4:0] x;
   logic [2:0] y;
   logic [5:0] six;
   logic [3:0] four;
   logic rd_mid;

   assign x = octet[4:0];
   assign y = octet[7:5];

   // Subblocks pick polarity from the running disparity; rd flips when the symbol is unbalanced
   always_comb begin
      six = T6[x];
      if (rd_in && (($countones(six) != 3) || (x == 5'h07))) begin
         six = ~six;
      end
      rd_mid = rd_in ^ ($countones(six) != 3);
      four = T4[y];
      if ((y == 3'h7) && ((!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)))) begin
         four = ALT7;
      end
      if (rd_mid && (($countones(four) != 2) || (y == 3'h3))) begin
         four = ~four;
      end
      symbol = {six, four};
      if (is_k) begin
         symbol = rd_in ? ~{K28_6B, K4[y]} : {K28_6B, K4[y]};
      end
      rd_out = rd_in ^ ($countones(symbol) != 5);
   end
endmodule
`default_nettype wire

// ==== logic/link_transmit_block.sv ====
// Two-link, four-lane transmit framer: packing, tails, scrambling, alignment sequence and encoding
`default_nettype none
`include "framer_regs.svh"
module link_transmit_block (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cfg_wr,
   input wire logic [15:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic tune_done,
   input wire framer_pkg::link_cfg_s cfg_ab,
   input wire framer_pkg::link_cfg_s cfg_cd,
   input wire logic [3:0][15:0] samples_ab,
   input wire logic [3:0][15:0] samples_cd,
   input wire logic [3:0] overrange_ab,
   input wire logic [3:0] overrange_cd,
   input wire logic [3:0] fast_detect_ab,
   input wire logic [3:0] fast_detect_cd,
   input wire logic system_reference_input,
   input wire logic sync_request_pair_one_n,
   input wire logic sync_request_pair_two_n,
   output logic [1:0] sample_take,
   output framer_pkg::link_derived_s derived_ab,
   output framer_pkg::link_derived_s derived_cd,
   output framer_pkg::link_state_e state_ab,
   output framer_pkg::link_state_e state_cd,
   output logic [9:0] pair_one_lane_zero,
   output logic [9:0] pair_one_lane_one,
   output logic [9:0] pair_two_lane_zero,
   output logic [9:0] pair_two_lane_one
);
   import framer_pkg::*;

   // Expected (address, data) at each step of the tuning sequence
   function automatic logic [23:0] tune_expect(input logic [2:0] step);
      case (step)
         3'h0: tune_expect = {`TUNE_B_ADDR, `TUNE_B_VAL0};
         3'h1: tune_expect = {`TUNE_B_ADDR, `TUNE_B_VAL1};
         3'h2: tune_expect = {`TUNE_A_ADDR, `TUNE_A_VAL0};
         3'h3: tune_expect = {`TUNE_A_ADDR, `TUNE_A_VAL1};
         3'h4: tune_expect = {`TUNE_C_ADDR, `TUNE_C_VAL0};
         default: tune_expect = {`TUNE_C_ADDR, `TUNE_C_VAL1};
      endcase
   endfunction

   // Log2 of converters per lane, floored at zero
   function automatic logic [1:0] cpl_log(input link_cfg_s c);
      cpl_log = (c.m_sel > {1'b0, c.lanes2}) ? 2'(c.m_sel - {1'b0, c.lanes2}) : 2'h0;
   endfunction

   // Log2 of samples per converter per frame
   function automatic logic [1:0] s_log(input link_cfg_s c);
      logic [2:0] used;
      used = {1'b0, cpl_log(c)} + {2'b0, c.wide_word};
      s_log = ({1'b0, c.f_sel} > used) ? 2'(3'({1'b0, c.f_sel}) - used) : 2'h0;
   endfunction

   // Sample bits MSB first, then control bits from bit 2 down, then tail bits
   function automatic logic [15:0] fmt_word(input logic [15:0] smp, input link_cfg_s c,
                                            input logic [2:0] ctl, input logic [14:0] prn);
      logic [4:0] ncs;
      fmt_word = '0;
      ncs = c.res_n + {3'b0, c.cs};
      for (int i = 0; i < `WORD_W; i++) begin
         if (5'(i) < c.res_n) begin
            fmt_word[15 - i] = smp[15 - i];
         end else if (5'(i) < ncs) begin
            fmt_word[15 - i] = ctl[2'(5'd2 - (5'(i) - c.res_n))];
         end else begin
            fmt_word[15 - i] = c.tail_prn & prn[i % 15];
         end
      end
   endfunction

   // Self-synchronizing scrambler, octet MSB first; returns {state, octet}
   function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
      logic [14:0] st;
      logic [7:0] q;
      st = s;
      q = '0;
      for (int i = 7; i >= 0; i--) begin
         q[i] = d[i] ^ st[13] ^ st[14];
         st = {st[13:0], q[i]};
      end
      scramble = {st, q};
   endfunction

   link_cfg_s cfg [2];
   logic [3:0][15:0] smp [2];
   logic [3:0] ovr [2];
   logic [3:0] fdet [2];
   logic [1:0] sync_n;

   logic [7:0] tune_a_r, tune_b_r, tune_c_r, rdata_r;
   logic [2:0] step_r;
   logic system_reference_input_q_r;
   logic [2:0] octet_r [2];
   logic [4:0] frame_r [2];
   logic [1:0] mf_r [2];
   link_state_e state_r [2];
   logic [14:0] prn_r [2];
   logic [7:0] low_r [4];
   logic [14:0] scr_r [4];
   logic [9:0] sym_r [4];
   logic rd_r [4];

   logic system_reference_input_edge;
   logic [2:0] f_last [2];
   logic [4:0] k_last [2];
   logic mf_end [2];
   logic [7:0] mf_pos [2];
   logic [1:0] conv [4];
   logic [15:0] fmt_w [4];
   logic first_w [4];
   logic [7:0] data_b [4];
   logic [7:0] scr_b [4];
   logic [14:0] scr_nxt [4];
   logic [7:0] oct_d [4];
   logic oct_k [4];
   logic [9:0] code [4];
   logic rd_nxt [4];

   assign cfg[0] = cfg_ab;
   assign cfg[1] = cfg_cd;
   assign smp[0] = samples_ab;
   assign smp[1] = samples_cd;
   assign ovr[0] = overrange_ab;
   assign ovr[1] = overrange_cd;
   assign fdet[0] = fast_detect_ab;
   assign fdet[1] = fast_detect_cd;
   assign sync_n = {sync_request_pair_two_n, sync_request_pair_one_n};

   // tuning sequence tracker; links stay in code group sync until it completes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         step_r <= 3'h0;
      end else if (cfg_wr) begin
         if (step_r != `TUNE_STEPS && {cfg_addr, cfg_wdata} == tune_expect(step_r)) begin
            step_r <= step_r + 3'h1;
         end else if ({cfg_addr, cfg_wdata} == tune_expect(3'h0)) begin
            step_r <= 3'h1; // a fresh first write restarts
         end else if (cfg_addr == `TUNE_A_ADDR || cfg_addr == `TUNE_B_ADDR || cfg_addr == `TUNE_C_ADDR) begin
            step_r <= 3'h0;
         end
      end
   end
   assign tune_done = (step_r == `TUNE_STEPS);

   // Tuning register storage and registered read-back
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tune_a_r <= `REG_RESET;
         tune_b_r <= `REG_RESET;
         tune_c_r <= `REG_RESET;
         rdata_r <= `REG_RESET;
      end else begin
         if (cfg_wr && cfg_addr == `TUNE_A_ADDR) tune_a_r <= cfg_wdata;
         if (cfg_wr && cfg_addr == `TUNE_B_ADDR) tune_b_r <= cfg_wdata;
         if (cfg_wr && cfg_addr == `TUNE_C_ADDR) tune_c_r <= cfg_wdata;
         case (cfg_addr)
            `TUNE_A_ADDR: rdata_r <= tune_a_r;
            `TUNE_B_ADDR: rdata_r <= tune_b_r;
            `TUNE_C_ADDR: rdata_r <= tune_c_r;
            default: rdata_r <= `REG_RESET;
         endcase
      end
   end
   assign cfg_rdata = rdata_r;

   // frame and multiframe boundaries per link
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         f_last[l] = 3'((4'h1 << cfg[l].f_sel) - 4'h1);
         k_last[l] = {cfg[l].k_sel, 2'b11}; // K = 4 * (k_sel + 1)
         mf_end[l] = (octet_r[l] == f_last[l]) && (frame_r[l] == k_last[l]);
         mf_pos[l] = 8'({3'b0, frame_r[l]} << cfg[l].f_sel) + {5'b0, octet_r[l]};
      end
   end

   assign system_reference_input_edge = system_reference_input & ~system_reference_input_q_r;

   // a reference edge restarts the frame and multiframe count of both links together
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         system_reference_input_q_r <= 1'b0;
         for (int l = 0; l < 2; l++) begin
            octet_r[l] <= 3'h0;
            frame_r[l] <= 5'h0;
            prn_r[l] <= `PRN_SEED;
         end
      end else begin
         system_reference_input_q_r <= system_reference_input;
         for (int l = 0; l < 2; l++) begin
            prn_r[l] <= {prn_r[l][13:0], prn_r[l][14] ^ prn_r[l][13]};
            if (system_reference_input_edge) begin
               octet_r[l] <= 3'h0;
               frame_r[l] <= 5'h0;
            end else if (octet_r[l] == f_last[l]) begin
               octet_r[l] <= 3'h0;
               frame_r[l] <= (frame_r[l] == k_last[l]) ? 5'h0 : frame_r[l] + 5'h1;
            end else begin
               octet_r[l] <= octet_r[l] + 3'h1;
            end
         end
      end
   end

   // link phase per link; a sync request always wins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int l = 0; l < 2; l++) begin
            state_r[l] <= ST_CGS;
            mf_r[l] <= 2'h0;
         end
      end else begin
         for (int l = 0; l < 2; l++) begin
            if (!tune_done || !sync_n[l]) begin
               state_r[l] <= ST_CGS;
            end else begin
               case (state_r[l])
                  ST_CGS: begin
                     mf_r[l] <= 2'h0;
                     if (mf_end[l]) state_r[l] <= ST_ILAS;
                  end
                  ST_ILAS: begin
                     if (mf_end[l]) begin
                        mf_r[l] <= mf_r[l] + 2'h1;
                        if (mf_r[l] == `ILAS_LAST_MF) state_r[l] <= ST_DATA;
                     end
                  end
                  ST_DATA: state_r[l] <= ST_DATA;
                  default: state_r[l] <= ST_CGS;
               endcase
            end
         end
      end
   end

   // Octet selection per lane; lane n belongs to link n/2
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         // converter from derived converters-per-lane and S
         conv[n] = 2'((2'(n % 2) << cpl_log(cfg[n / 2])) +
                   ((cfg[n / 2].wide_word ? {1'b0, octet_r[n / 2][2:1]} : octet_r[n / 2]) >> s_log(cfg[n / 2])));
         fmt_w[n] = fmt_word(smp[n / 2][conv[n]], cfg[n / 2],
                             {ovr[n / 2][conv[n]], system_reference_input_q_r, fdet[n / 2][conv[n]]}, prn_r[n / 2]);
         first_w[n] = !cfg[n / 2].wide_word || !octet_r[n / 2][0];
         data_b[n] = first_w[n] ? fmt_w[n][15:8] : low_r[n];
         {scr_nxt[n], scr_b[n]} = scramble(data_b[n], scr_r[n]);
         oct_k[n] = 1'b1;
         oct_d[n] = `K28_5;
         if ((n % 2 == 0) || cfg[n / 2].lanes2) begin
            if (state_r[n / 2] == ST_ILAS) begin
               oct_k[n] = 1'b0;
               oct_d[n] = mf_pos[n / 2];
               if (mf_pos[n / 2] == 8'h00) begin
                  oct_k[n] = 1'b1;
                  oct_d[n] = `K28_0;
               end else if (mf_end[n / 2]) begin
                  oct_k[n] = 1'b1;
                  oct_d[n] = `K28_3;
               end else if (mf_r[n / 2] == `ILAS_CFG_MF && mf_pos[n / 2] == `ILAS_Q_POS) begin
                  oct_k[n] = 1'b1;
                  oct_d[n] = `K28_4;
               end
            end else if (state_r[n / 2] == ST_DATA) begin
               oct_k[n] = 1'b0;
               oct_d[n] = cfg[n / 2].scramble_en ? scr_b[n] : data_b[n];
            end
         end
      end
   end

   // one encoder per lane, four lanes
   for (genvar g = 0; g < 4; g++) begin : g_enc
      enc_8b10b u_enc (
         .octet(oct_d[g]),
         .is_k(oct_k[g]),
         .rd_in(rd_r[g]),
         .symbol(code[g]),
         .rd_out(rd_nxt[g])
      );
   end

   // Lane state: low octet hold, scrambler history, disparity, output symbol
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int n = 0; n < 4; n++) begin
            low_r[n] <= 8'h00;
            scr_r[n] <= 15'h0000;
            sym_r[n] <= 10'h000;
            rd_r[n] <= 1'b0;
         end
      end else begin
         for (int n = 0; n < 4; n++) begin
            if (first_w[n]) low_r[n] <= fmt_w[n][7:0];
            // Scrambler runs only on user data; the alignment sequence is never scrambled
            if (state_r[n / 2] == ST_DATA && cfg[n / 2].scramble_en) scr_r[n] <= scr_nxt[n];
            sym_r[n] <= code[n];
            rd_r[n] <= rd_nxt[n];
         end
      end
   end

   // no control words; sample_take marks word starts in user data
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         sample_take[l] = (state_r[l] == ST_DATA) && (!cfg[l].wide_word || !octet_r[l][0]);
      end
   end

   assign derived_ab = '{s: 4'(4'h1 << s_log(cfg[0])), hd: cfg[0].lanes2 && (cfg[0].m_sel == 2'h0)};
   assign derived_cd = '{s: 4'(4'h1 << s_log(cfg[1])), hd: cfg[1].lanes2 && (cfg[1].m_sel == 2'h0)};
   assign state_ab = state_r[0];
   assign state_cd = state_r[1];
   assign pair_one_lane_zero = sym_r[0];
   assign pair_one_lane_one = sym_r[1];
   assign pair_two_lane_zero = sym_r[2];
   assign pair_two_lane_one = sym_r[3];
endmodule
`default_nettype wire

// ==== pkg/framer_pkg.sv ====
// Types shared by the transmit framer, its checks and its bench
`default_nettype none
package framer_pkg;

   // Per-link transport and data link settings
   typedef struct packed {
      logic lanes2;       // L = 2 when set, else L = 1
      logic [1:0] m_sel;  // M = 1 << m_sel (1, 2, 4)
      logic [1:0] f_sel;  // F = 1 << f_sel (1, 2, 4, 8)
      logic wide_word;    // N' = 16 when set, else 8
      logic [4:0] res_n;  // N, 7 to 16
      logic [1:0] cs;     // Control bits per sample, 0 to 3
      logic [2:0] k_sel;  // K = 4 * (k_sel + 1)
      logic scramble_en;
      logic tail_prn;     // Tail bits from PRN when set, else zero
   } link_cfg_s;

   // Values the link works out for itself
   typedef struct packed {
      logic [3:0] s;
      logic hd;
   } link_derived_s;

   typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA} link_state_e;

endpackage
`default_nettype wire

// ==== pkg/framer_regs.svh ====
// Register addresses, tuning values, control characters and field constants for the framer
`ifndef FRAMER_REGS_SVH
`define FRAMER_REGS_SVH

`define TUNE_A_ADDR 16'h1222
`define TUNE_B_ADDR 16'h1228
`define TUNE_C_ADDR 16'h1262
`define TUNE_B_VAL0 8'h4f
`define TUNE_B_VAL1 8'h0f
`define TUNE_A_VAL0 8'h04
`define TUNE_A_VAL1 8'h00
`define TUNE_C_VAL0 8'h08
`define TUNE_C_VAL1 8'h00
`define TUNE_STEPS 3'h6
`define REG_RESET 8'h00
`define K28_0 8'h1c
`define K28_3 8'h7c
`define K28_4 8'h9c
`define K28_5 8'hbc
`define ILAS_LAST_MF 2'h3
`define ILAS_CFG_MF 2'h1
`define ILAS_Q_POS 8'h01
`define PRN_SEED 15'h7fff
`define WORD_W 16

`endif

// ==== sim/link_transmit_block_asserts.sv ====
// Concurrent checks on the framer's top ports
`default_nettype none
module framer_checks (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cfg_wr,
   input wire logic [15:0] cfg_addr,
   input wire logic [7:0] cfg_rdata,
   input wire logic tune_done,
   input wire framer_pkg::link_cfg_s cfg_ab,
   input wire framer_pkg::link_cfg_s cfg_cd,
   input wire logic sync_request_pair_one_n,
   input wire logic sync_request_pair_two_n,
   input wire framer_pkg::link_derived_s derived_ab,
   input wire framer_pkg::link_state_e state_ab,
   input wire framer_pkg::link_state_e state_cd,
   input wire logic [9:0] pair_one_lane_zero,
   input wire logic [9:0] pair_two_lane_one
);
   timeunit 1ns;
   timeprecision 1ps;
   import framer_pkg::*;
   logic [3:0] up_r;
   logic [9:0] ilas_r;
   logic [9:0] ilas_len;
   logic [7:0] s_exp;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Either disparity form of a control character is accepted
   function automatic logic is_k(input logic [9:0] v, input logic [9:0] c);
      return v == c || v == ~c;
   endfunction
   // Cycles since reset; lanes show zeros until the pipe fills
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         up_r <= 4'h0;
      else if (up_r != 4'hf)
         up_r <= up_r + 4'h1;
   end
   // Length of the alignment phase so far
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         ilas_r <= 10'h0;
      else
         ilas_r <= (state_ab == ST_ILAS) ? ilas_r + 10'h1 : 10'h0;
   end
   // Four multiframes of K frames of F octets
   assign ilas_len = ({7'h0, cfg_ab.k_sel} + 10'h1) << ({8'h0, cfg_ab.f_sel} + 10'h4);
   assign s_exp = 8'(((16'h8 << cfg_ab.f_sel) * (cfg_ab.lanes2 ? 16'h2 : 16'h1))
                  / ((16'h1 << cfg_ab.m_sel) * (cfg_ab.wide_word ? 16'h10 : 16'h8)));
   a_sync_forces_cgs: assert property (!sync_request_pair_one_n |=> state_ab == ST_CGS)
      else $error("link one left code group phase while sync low");
   a_sync_cd_cgs: assert property (!sync_request_pair_two_n |=> state_cd == ST_CGS)
      else $error("link two left code group phase while sync low");
   a_cgs_sends_comma: assert property (up_r > 4'h3 && state_ab == ST_CGS && $past(state_ab) == ST_CGS
      && $past(state_ab, 2) == ST_CGS |-> is_k(pair_one_lane_zero, 10'h0fa))
      else $error("comma missing during code group phase");
   a_cgs_then_ilas: assert property ($past(state_ab) == ST_CGS && state_ab != ST_CGS
      |-> state_ab == ST_ILAS && tune_done && $past(sync_request_pair_one_n))
      else $error("bad exit from code group phase");
   a_ilas_length: assert property (state_ab == ST_DATA && $past(state_ab) == ST_ILAS
      |-> $past(ilas_r) == ilas_len - 10'h1)
      else $error("alignment phase length wrong");
   a_ilas_opens_r: assert property ($rose(state_ab == ST_ILAS) |-> ##[1:3] is_k(pair_one_lane_zero, 10'h0f4))
      else $error("alignment phase did not open with start character");
   a_idle_lane_comma: assert property (up_r > 4'h3 && !cfg_cd.lanes2 |-> is_k(pair_two_lane_one, 10'h0fa))
      else $error("unused lane not sending commas");
   a_untuned_stays_cgs: assert property (!tune_done && !$past(tune_done) && !$past(tune_done, 2)
      |-> state_ab == ST_CGS)
      else $error("link left code group phase before tuning");
   a_tune_lost_by_write: assert property ($fell(tune_done) |-> $past(cfg_wr))
      else $error("tuning flag dropped without a write");
   a_unmapped_reads_zero: assert property (cfg_addr != 16'h1222 && cfg_addr != 16'h1228
      && cfg_addr != 16'h1262 |=> cfg_rdata == 8'h00)
      else $error("unmapped address read nonzero");
   a_derived_spf: assert property (s_exp != 8'h0 |-> derived_ab.s == s_exp[3:0])
      else $error("derived samples per frame wrong");
   c_ilas: cover property ($rose(state_ab == ST_ILAS));
   c_data: cover property ($rose(state_ab == ST_DATA));
   c_tuned: cover property ($rose(tune_done));
endmodule
bind link_transmit_block framer_checks chk (.ref_clk, .rst, .cfg_wr, .cfg_addr, .cfg_rdata, .tune_done, .cfg_ab,
   .cfg_cd, .sync_request_pair_one_n, .sync_request_pair_two_n, .derived_ab, .state_ab, .state_cd,
   .pair_one_lane_zero, .pair_two_lane_one);
`default_nettype wire

// ==== sim/link_transmit_block_bench.sv ====
// Self-checking bench for the two-link transmit framer
`default_nettype none
`include "framer_regs.svh"
module link_transmit_block_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import framer_pkg::*;
   logic ref_clk, rst, cfg_wr, go_ab, go_cd, rd_chk, lane_act, sref, tune_done, sync_ab_n, sync_cd_n;
   logic [15:0] cfg_addr;
   logic [7:0] cfg_wdata, cfg_rdata, v;
   link_cfg_s cfg_ab, cfg_cd;
   logic [3:0][15:0] smp_ab, smp_cd;
   logic [3:0] ovr_ab, ovr_cd, fd_ab, fd_cd;
   link_derived_s der_ab, der_cd;
   link_state_e st_ab, st_cd;
   logic [9:0] l0, l1, l2, l3;
   logic [20:0] e;
   logic [1:0] take;
   logic [7:0] reg_q[$];
   logic [20:0] lane_q[$];
   logic [23:0] wq[$];
   int bad_count, num_checks, n;
   link_transmit_block uut (.ref_clk, .rst, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata, .tune_done, .cfg_ab,
      .cfg_cd, .samples_ab(smp_ab), .samples_cd(smp_cd), .overrange_ab(ovr_ab), .overrange_cd(ovr_cd),
      .fast_detect_ab(fd_ab), .fast_detect_cd(fd_cd), .system_reference_input(sref),
      .sync_request_pair_one_n(sync_ab_n), .sync_request_pair_two_n(sync_cd_n), .sample_take(take),
      .derived_ab(der_ab), .derived_cd(der_cd), .state_ab(st_ab), .state_cd(st_cd), .pair_one_lane_zero(l0),
      .pair_one_lane_one(l1), .pair_two_lane_zero(l2), .pair_two_lane_one(l3));
   rx_partner rx_ab (.ref_clk, .rst, .go(go_ab), .lane(l0), .sync_n(sync_ab_n));
   rx_partner rx_cd (.ref_clk, .rst, .go(go_cd), .lane(l2), .sync_n(sync_cd_n));
   // Mirror image of a code is the same character in the other disparity
   function automatic logic [9:0] norm(input logic [9:0] g, input logic [9:0] x);
      return (g === ~x) ? x : g;
   endfunction
   task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Back to back writes: the strobe stays up between entries
   task automatic flush_writes();
      while (wq.size() > 0) begin
         {cfg_addr, cfg_wdata} <= wq[0];
         cfg_wr <= 1'b1;
         wq.pop_front();
         @(posedge ref_clk);
      end
      cfg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      cfg_addr <= a;
      @(posedge ref_clk);
      rd_chk <= 1'b1;
      reg_q.push_back(x);
      @(posedge ref_clk);
      rd_chk <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wait_state(input link_state_e s);
      n = 0;
      while (st_ab !== s && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      if (st_ab !== s) begin
         bad_count++;
         $display("[FAIL] link state expected %0d seen %0d", s, st_ab);
         tally_and_finish();
      end
   endtask
   // Locks on the high octet symbol, then notes six alternating symbols, three frames
   task automatic lanes(input logic [9:0] h0, input logic [9:0] lo0, input logic [9:0] h1, input logic [9:0] lo1);
      n = 0;
      repeat (4) @(negedge ref_clk);
      while (norm(l0, h0) !== h0 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 40) begin
         bad_count++;
         $display("[FAIL] lane lock expected %h seen %h", h0, l0);
         tally_and_finish();
      end
      for (int i = 0; i < 6; i++)
         lane_q.push_back(i[0] ? {1'b1, lo0, lo1} : {1'b0, h0, h1});
      lane_act = 1'b1;
      while (lane_q.size() > 0)
         @(posedge ref_clk);
      lane_act = 1'b0;
   endtask
   // Lane monitor: sampled values at the edge are the settled ones
   always @(posedge ref_clk) begin
      if (lane_act && lane_q.size() > 0) begin
         e = lane_q.pop_front();
         chk("lane pair", e[19:0], {norm(l0, e[19:10]), norm(l1, e[9:0])});
         // While the high symbol shows, the low octet is in flight, so no new word is taken
         chk("sample_take", 20'(e[20]), 20'(take[0]));
      end
   end
   // Register read monitor
   always @(negedge ref_clk) begin
      if (rd_chk)
         chk("cfg_rdata", 20'(reg_q.pop_front()), 20'(cfg_rdata));
   end
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      void'($urandom(32'h2289));
      rst = 1'b1;
      {cfg_wr, go_ab, go_cd, rd_chk, lane_act, sref, cfg_addr, cfg_wdata} = '0;
      {ovr_ab, ovr_cd, fd_ab, fd_cd} = 16'($urandom());
      ovr_ab = 4'h0;
      smp_ab = {16'h0, 16'h0, 16'h0800, 16'h0400};
      smp_cd = 64'({$urandom(), $urandom()});
      // Scrambler off on link one so its symbols can be read directly
      cfg_ab = '{lanes2: 1, m_sel: 1, f_sel: 1, wide_word: 1, res_n: 14, cs: 0, k_sel: 0, default: 0};
      cfg_cd = '{lanes2: 0, m_sel: 1, f_sel: 2, wide_word: 1, res_n: 14, cs: 0, k_sel: 1, default: 1};
      fork
         for (int i = 0; i < 64; i++) begin
            {cfg_cd.lanes2, cfg_cd.m_sel, cfg_cd.f_sel, cfg_cd.wide_word} = 6'(i);
            #1;
            v = 8'(((8 << cfg_cd.f_sel) * (cfg_cd.lanes2 + 1)) / ((1 << cfg_cd.m_sel) * (cfg_cd.wide_word ? 16 : 8)));
            // One converter on two lanes and eight converters lie outside the supported set
            if (cfg_cd.m_sel != 2'h3 && !(cfg_cd.lanes2 && cfg_cd.m_sel == 2'h0) && v != 8'h0)
               chk("derived s", 20'(v), 20'(der_cd.s));
         end
         repeat (20) @(posedge ref_clk);
      join
      cfg_cd = '{lanes2: 0, m_sel: 1, f_sel: 2, wide_word: 1, res_n: 14, cs: 0, k_sel: 1, default: 1};
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(16'h0000, 8'h00);
      v = 8'($urandom());
      wq.push_back({`TUNE_C_ADDR, v});
      flush_writes();
      @(posedge ref_clk);
      rd(`TUNE_C_ADDR, v);
      wq = '{{`TUNE_B_ADDR, `TUNE_B_VAL0}, {`TUNE_B_ADDR, `TUNE_B_VAL1}, {`TUNE_A_ADDR, `TUNE_A_VAL0},
             {`TUNE_C_ADDR, 8'h55}};
      flush_writes();
      @(posedge ref_clk);
      chk("tune_done", 20'h0, 20'(tune_done));
      wq = '{{`TUNE_B_ADDR, `TUNE_B_VAL0}, {`TUNE_B_ADDR, `TUNE_B_VAL1}, {`TUNE_A_ADDR, `TUNE_A_VAL0},
             {`TUNE_A_ADDR, `TUNE_A_VAL1}, {`TUNE_C_ADDR, `TUNE_C_VAL0}, {`TUNE_C_ADDR, `TUNE_C_VAL1}};
      flush_writes();
      @(posedge ref_clk);
      chk("tune_done", 20'h1, 20'(tune_done));
      sref <= 1'b1;
      @(posedge ref_clk);
      sref <= 1'b0;
      repeat ($urandom_range(9)) @(posedge ref_clk);
      go_ab <= 1'b1;
      go_cd <= 1'b1;
      wait_state(ST_ILAS);
      wait_state(ST_DATA);
      lanes(10'h354, 10'h274, 10'h394, 10'h274);
      cfg_ab.cs <= 2'h1;
      ovr_ab <= 4'h1;
      lanes(10'h354, 10'h2d4, 10'h394, 10'h274);
      // Link two has longer multiframes, so it reaches user data later than link one
      n = 0;
      while (st_cd !== ST_DATA && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      chk("link two state", 20'(ST_DATA), 20'(st_cd));
      if (st_cd !== ST_DATA)
         tally_and_finish();
      @(posedge ref_clk);
      chk("link two data", 20'h0, 20'(norm(l2, 10'h0fa) === 10'h0fa));
      go_ab <= 1'b0;
      wait_state(ST_CGS);
      repeat (3) @(posedge ref_clk);
      chk("comma", 20'h0fa, 20'(norm(l0, 10'h0fa)));
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== sim/rx_partner.sv ====
// Receiver stand-in that holds sync low until it has seen commas
`default_nettype none
module rx_partner (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [9:0] lane,
   output logic sync_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] comma_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         comma_r <= 3'h0;
      else if (lane == 10'h0fa || lane == 10'h305)
         comma_r <= (comma_r == 3'h4) ? comma_r : comma_r + 3'h1;
      else if (!sync_n)
         comma_r <= 3'h0;
   end
   // sync release
   // Dropping go is how the bench asks for a resync
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         sync_n <= 1'b0;
      else if (!go)
         sync_n <= 1'b0;
      else if (comma_r == 3'h4)
         sync_n <= 1'b1;
   end
endmodule
`default_nettype wire
